// >>> test/e1pm_counters_checker.sv
// Assertion checker for the E1 performance error counters
module e1pm_counters_checker #(
	parameter int LONG_CYCLES = 100,
	parameter int SHORT_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic short_period_select,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic interval_tick_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap_q;
	logic seen_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 0;
			seen_q <= 1'b0;
		end else begin
			gap_q <= interval_tick_flag ? 1 : gap_q + 1;
			seen_q <= seen_q | interval_tick_flag;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_tick_alone: assert property (
		interval_tick_flag |=> !interval_tick_flag [*8]) else $error("tick long");
	chk_long_period: assert property (
		interval_tick_flag && !short_period_select |-> gap_q == LONG_CYCLES)
		else $error("long period");
	chk_short_period: assert property (
		interval_tick_flag && short_period_select
		&& $past(short_period_select, SHORT_CYCLES) |-> gap_q == SHORT_CYCLES)
		else $error("short period");
	chk_gap_bound: assert property (
		gap_q <= LONG_CYCLES) else $error("tick missing");
	chk_short_bound: assert property (
		short_period_select && $past(short_period_select, SHORT_CYCLES)
		|-> gap_q <= SHORT_CYCLES) else $error("short tick missing");
	chk_unmapped_zero: assert property (
		$past(rd_addr) > 8'h05 |-> rd_data == 8'h00) else $error("unmapped");
	chk_held_stable: assert property (
		!interval_tick_flag && !$past(interval_tick_flag) && $stable(rd_addr)
		|=> $stable(rd_data)) else $error("read data moved");
	chk_first_zero: assert property (
		!seen_q |-> rd_data == 8'h00) else $error("early count");
	cover property (interval_tick_flag && short_period_select);
	cover property ($past(rd_addr) == 8'h02 && rd_data == 8'h46);
	cover property ($past(rd_addr) == 8'hFF);
endmodule : e1pm_counters_checker

// >>> test/e1pm_counters_tb_top.sv
// Testbench for the E1 performance error counters
module e1pm_counters_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LONG_CYCLES = 1200;
	localparam int SHORT_CYCLES = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic short_period_select = 1'b0;
	logic violation_type_select = 1'b0;
	logic [9:0] ev = 10'h000;
	logic [7:0] rd_addr = 8'h00;
	logic [7:0] rd_data;
	logic interval_tick_flag;
	int miscompares = 0;
	int n_tests = 0;
	int n;
	e1pm_counters #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) uut (
		.clk, .rst_n, .short_period_select, .violation_type_select,
		.receive_hdb3_enable(ev[0]), .bipolar_violation(ev[9]),
		.hdb3_codeword(ev[8]), .code_violation(ev[7]),
		.checksum_word_error(ev[6]), .far_end_bit_strobe(ev[5]),
		.far_end_bit_value(ev[4]), .alignment_word_error(ev[3]),
		.receive_sync_lost_flag(ev[2]), .checksum_mf_sync_lost(ev[1]),
		.rd_addr, .rd_data, .interval_tick_flag);
	task put(input logic [9:0] v);
		@(negedge clk);
		ev = v;
	endtask : put
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		rd_addr = a;
		@(negedge clk);
		chk("rd_data", e, rd_data);
	endtask : rd
	task wait_tick();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (interval_tick_flag !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			$display("FAIL interval_tick_flag expected 1 seen 0");
		end
	endtask : wait_tick
	task t_counts();
		logic [7:0] e [6] = '{8'h03, 8'hE9, 8'h46, 8'h58, 8'h31, 8'h2C};
		wait_tick();
		for (int i = 0; i < 1099; i++)
			put({i < 999, 2'b00, i < 600, i < 300, 5'b01000});
		put(10'b0001101010);
		put(10'b1001101100);
		put(10'b1110110001);
		put(10'b1100000000);
		put(10'h000);
		wait_tick();
		for (int a = 0; a < 6; a++)
			rd(8'(a), e[a]);
	endtask : t_counts
	task t_code();
		violation_type_select = 1'b1;
		repeat (5) put(10'h080);
		repeat (3) put(10'h200);
		put(10'h000);
		wait_tick();
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h05);
		rd(8'h03, 8'h00);
		violation_type_select = 1'b0;
	endtask : t_code
	task t_unmapped();
		rd(8'h06, 8'h00);
		rd(8'hFF, 8'h00);
	endtask : t_unmapped
	task t_short();
		repeat (30) @(negedge clk);
		short_period_select = 1'b1;
		wait_tick();
		wait_tick();
		chk("tick_gap", 8'(SHORT_CYCLES), 8'(n));
	endtask : t_short
	task give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial forever #10 clk = ~clk;
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_counts();
		t_code();
		t_unmapped();
		t_short();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("FAIL run_end expected finish seen timeout");
		give_verdict();
	end
endmodule : e1pm_counters_tb_top
bind e1pm_counters e1pm_counters_checker #(.LONG_CYCLES(LONG_CYCLES),
	.SHORT_CYCLES(SHORT_CYCLES)) u_chk (.clk, .rst_n, .short_period_select,
	.rd_addr, .rd_data, .interval_tick_flag);

// >>> verilog/e1pm_cnt_if.sv
// Interface between the top and one interval counter
interface e1pm_cnt_if #(
	parameter int WIDTH = 16
);
	logic inc;
	logic run;
	logic tick;
	logic [WIDTH-1:0] count;
	modport ctrl (output inc, output run, output tick, input count);
	modport cnt (input inc, input run, input tick, output count);
endinterface : e1pm_cnt_if

// >>> verilog/e1pm_counters.sv
// Top of the E1 performance error counters with byte read port
// How it works
// - Violation count split over two bytes
// - Ten-bit checksum error counter, one per word
// - Checksum count MSB byte2 bit1, LSB byte3
// - Checksum, far-end stop on alignment/multiframe loss
// - Count zero E-bits from frames 13, 15
// - Far-end count MSB byte4 bit1, LSB byte5
// - Twelve-bit alignment counter, held during sync loss
// - Alignment count in bits 7..2 of 02, 04
// - Checksum top bits in low bits of 02
// - Far-end top bits in low bits of 04
// - No saturation for three small counters
// - Snapshot all counters each interval, restart
// - Bipolar violations less substitution codes, or code violations
// - Violation counter saturates, ignores sync loss
module e1pm_counters #(
	parameter int LONG_CYCLES = e1pm_pkg::LONG_PERIOD_CYCLES,
	parameter int SHORT_CYCLES = e1pm_pkg::SHORT_PERIOD_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic short_period_select,
	input wire logic violation_type_select,
	input wire logic receive_hdb3_enable,
	input wire logic bipolar_violation,
	input wire logic hdb3_codeword,
	input wire logic code_violation,
	input wire logic checksum_word_error,
	input wire logic far_end_bit_strobe,
	input wire logic far_end_bit_value,
	input wire logic alignment_word_error,
	input wire logic receive_sync_lost_flag,
	input wire logic checksum_mf_sync_lost,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	output logic interval_tick_flag
);
	typedef struct packed {
		logic [e1pm_pkg::TIMER_W-1:0] timer;
		logic tick;
		logic [7:0] rd_data;
	} e1pm_top_state_t;

	e1pm_top_state_t state_q;
	e1pm_top_state_t state_d;
	logic [e1pm_pkg::TIMER_W-1:0] limit;
	logic viol_event;
	logic fine_sync;
	logic align_run;
	logic substitution_code;
	logic far_end_zero;

	// Interval timer and read path
	logic timer_wrap;
	logic [7:0] read_byte;

	// Byte images of the held counts
	logic [e1pm_pkg::ALIGN_HALF_W-1:0] align_top;
	logic [e1pm_pkg::ALIGN_HALF_W-1:0] align_bottom;
	logic [7:0] viol_high_byte;
	logic [7:0] viol_low_byte;
	logic [7:0] crc_align_byte;
	logic [7:0] crc_low_byte;
	logic [7:0] feb_align_byte;
	logic [7:0] feb_low_byte;

	e1pm_cnt_if #(.WIDTH(e1pm_pkg::VIOL_W)) viol_if ();
	e1pm_cnt_if #(.WIDTH(e1pm_pkg::CHECKSUM_W)) crc_if ();
	e1pm_cnt_if #(.WIDTH(e1pm_pkg::FAR_END_W)) feb_if ();
	e1pm_cnt_if #(.WIDTH(e1pm_pkg::ALIGN_W)) fas_if ();

	////////////////////////////////////////////////////////////////////////
	// Event selection and gating
	assign substitution_code = receive_hdb3_enable && hdb3_codeword;

	always_comb begin
		viol_event = 1'b0;
		case (violation_type_select)
			1'b1: begin
				viol_event = code_violation;
			end
			default: begin
				viol_event = bipolar_violation &&
					!substitution_code;
			end
		endcase
	end

	assign fine_sync = !receive_sync_lost_flag && !checksum_mf_sync_lost;
	assign align_run = !receive_sync_lost_flag;
	assign far_end_zero = far_end_bit_strobe && !far_end_bit_value;

	assign viol_if.inc = viol_event;
	assign viol_if.run = 1'b1;
	assign viol_if.tick = state_q.tick;

	assign crc_if.inc = checksum_word_error;
	assign crc_if.run = fine_sync;
	assign crc_if.tick = state_q.tick;

	assign feb_if.inc = far_end_zero;
	assign feb_if.run = fine_sync;
	assign feb_if.tick = state_q.tick;

	assign fas_if.inc = alignment_word_error;
	assign fas_if.run = align_run;
	assign fas_if.tick = state_q.tick;

	////////////////////////////////////////////////////////////////////////
	// Counters
	e1pm_interval_counter #(.WIDTH(e1pm_pkg::VIOL_W), .SATURATE(1'b1))
	u_viol (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(viol_if)
	);

	e1pm_interval_counter #(.WIDTH(e1pm_pkg::CHECKSUM_W), .SATURATE(1'b0))
	u_crc (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(crc_if)
	);

	e1pm_interval_counter #(.WIDTH(e1pm_pkg::FAR_END_W), .SATURATE(1'b0))
	u_feb (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(feb_if)
	);

	e1pm_interval_counter #(.WIDTH(e1pm_pkg::ALIGN_W), .SATURATE(1'b0))
	u_fas (
		.clk(clk),
		.rst_n(rst_n),
		.port_if(fas_if)
	);

	////////////////////////////////////////////////////////////////////////
	// Interval length
	always_comb begin
		if (short_period_select) begin
			limit = e1pm_pkg::TIMER_W'(SHORT_CYCLES - 1);
		end else begin
			limit = e1pm_pkg::TIMER_W'(LONG_CYCLES - 1);
		end
	end

	assign timer_wrap = (state_q.timer >= limit);

	////////////////////////////////////////////////////////////////////////
	// Byte images and read decode
	assign align_top = fas_if.count[11:6];
	assign align_bottom = fas_if.count[5:0];
	assign viol_high_byte = viol_if.count[15:8];
	assign viol_low_byte = viol_if.count[7:0];
	assign crc_align_byte = {align_top, crc_if.count[9:8]};
	assign crc_low_byte = crc_if.count[7:0];
	assign feb_align_byte = {align_bottom, feb_if.count[9:8]};
	assign feb_low_byte = feb_if.count[7:0];

	always_comb begin
		read_byte = e1pm_pkg::READ_DATA_RESET;
		case (rd_addr)
			e1pm_pkg::VIOLATION_COUNT_HIGH_ADDR: begin
				read_byte = viol_high_byte;
			end
			e1pm_pkg::VIOLATION_COUNT_LOW_ADDR: begin
				read_byte = viol_low_byte;
			end
			e1pm_pkg::CHECKSUM_ALIGN_HIGH_ADDR: begin
				read_byte = crc_align_byte;
			end
			e1pm_pkg::CHECKSUM_COUNT_LOW_ADDR: begin
				read_byte = crc_low_byte;
			end
			e1pm_pkg::FAR_END_ALIGN_LOW_ADDR: begin
				read_byte = feb_align_byte;
			end
			e1pm_pkg::FAR_END_COUNT_LOW_ADDR: begin
				read_byte = feb_low_byte;
			end
			default: begin
				read_byte = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Interval timer and read data register
	always_comb begin
		state_d = state_q;
		if (timer_wrap) begin
			state_d.timer = '0;
			state_d.tick = 1'b1;
		end else begin
			state_d.timer = state_q.timer + e1pm_pkg::TIMER_W'(1);
			state_d.tick = 1'b0;
		end
		state_d.rd_data = read_byte;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q.timer <= e1pm_pkg::TIMER_RESET;
			state_q.tick <= 1'b0;
			state_q.rd_data <= e1pm_pkg::READ_DATA_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign rd_data = state_q.rd_data;
	assign interval_tick_flag = state_q.tick;
endmodule : e1pm_counters

// >>> verilog/e1pm_interval_counter.sv
// One interval counter with snapshot on the interval tick
module e1pm_interval_counter #(
	parameter int WIDTH = 16,
	parameter bit SATURATE = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	e1pm_cnt_if.cnt port_if
);
	typedef struct packed {
		logic [WIDTH-1:0] acc;
		logic [WIDTH-1:0] held;
	} e1pm_cnt_state_t;

	e1pm_cnt_state_t state_q;
	e1pm_cnt_state_t state_d;
	logic [WIDTH-1:0] bumped;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		bumped = state_q.acc;
		if (port_if.inc && port_if.run) begin
			if (!SATURATE || (state_q.acc != {WIDTH{1'b1}})) begin
				bumped = state_q.acc + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
		if (port_if.tick) begin
			state_d.held = bumped;
			state_d.acc = '0;
		end else begin
			state_d.acc = bumped;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign port_if.count = state_q.held;
endmodule : e1pm_interval_counter

// >>> verilog/e1pm_pkg.sv
// Constants for the E1 performance error counters
package e1pm_pkg;
	// Clock rate
	localparam int CLK_MHZ = 50;
	// Interval lengths in microseconds
	localparam int LONG_PERIOD_US = 1000000;
	localparam int SHORT_PERIOD_US = 62500;
	localparam int LONG_PERIOD_CYCLES = LONG_PERIOD_US * CLK_MHZ;
	localparam int SHORT_PERIOD_CYCLES = SHORT_PERIOD_US * CLK_MHZ;
	localparam int TIMER_W = 26;
	// Counter widths
	localparam int VIOL_W = 16;
	localparam int CHECKSUM_W = 10;
	localparam int FAR_END_W = 10;
	localparam int ALIGN_W = 12;
	// Byte addresses
	localparam logic [7:0] VIOLATION_COUNT_HIGH_ADDR = 8'h00;
	localparam logic [7:0] VIOLATION_COUNT_LOW_ADDR = 8'h01;
	localparam logic [7:0] CHECKSUM_ALIGN_HIGH_ADDR = 8'h02;
	localparam logic [7:0] CHECKSUM_COUNT_LOW_ADDR = 8'h03;
	localparam logic [7:0] FAR_END_ALIGN_LOW_ADDR = 8'h04;
	localparam logic [7:0] FAR_END_COUNT_LOW_ADDR = 8'h05;
	// Field positions in the shared bytes
	localparam int ALIGN_FIELD_LSB = 2;
	localparam int ALIGN_HALF_W = 6;
	// Reset values
	localparam logic [7:0] READ_DATA_RESET = 8'h00;
	localparam logic [TIMER_W-1:0] TIMER_RESET = 26'h0000000;
endpackage : e1pm_pkg
